// ==== include/sqm_pkg.sv ====
package sqm_pkg;
	// Geometry
	localparam int NUM_QUEUES  = 64;
	localparam int LOW_QUEUES  = 32;
	localparam int SRAM_WORDS  = 2048;
	localparam int QID_W       = 6;
	localparam int WADDR_W     = 11;
	localparam int CNT_W       = 8;
	localparam int BUF_DEPTH   = 2;

	// Register map, byte offsets; low 8 bits select the queue, word aligned
	localparam logic [15:0] OFS_QDATA = 16'h0000; // queue entry port, +4*qid
	localparam logic [15:0] OFS_QCFG  = 16'h1000; // queue configuration, +4*qid
	localparam logic [15:0] OFS_QSTAT = 16'h2000; // status and count, +4*qid
	localparam logic [15:0] OFS_PEND  = 16'h3000; // pending low/high halves
	localparam logic [15:0] OFS_ENAB  = 16'h3008; // enable low/high halves
	localparam logic [15:0] OFS_SRAM  = 16'h4000; // direct SRAM window, 8 Kbyte

	// Configuration field positions
	localparam int CFG_BASE_LSB = 0;   // base word address, 11 bits
	localparam int CFG_SIZE_LSB = 11;  // 0:16 1:32 2:64 3:128 words
	localparam int CFG_ESZ_LSB  = 13;  // 0:1 1:2 2:4 words
	localparam int CFG_NE_LSB   = 15;  // code k: 0 or 2^(k-1)
	localparam int CFG_NF_LSB   = 18;
	localparam int CFG_SRC_LSB  = 21;  // flag select, 2 bits
	localparam int CFG_POL_LSB  = 23;  // polarity bit, stored only; either edge of the source sets pending
	localparam logic [23:0] CFG_RST = 24'h000000;

	// Status field positions
	localparam int ST_E = 0;
	localparam int ST_NE = 1;
	localparam int ST_NF = 2;
	localparam int ST_F = 3;
	localparam int ST_UF = 4;
	localparam int ST_OF = 5;
	localparam int ST_CNT_LSB = 8;

	typedef enum logic [1:0] {
		SRC_EMPTY,
		SRC_NEARLY_EMPTY,
		SRC_NEARLY_FULL,
		SRC_FULL
	} sqm_src_e;

	// Flag bus word towards the network processing engines
	typedef struct packed {
		logic [LOW_QUEUES-1:0] empty;
		logic [LOW_QUEUES-1:0] nearly_empty_flag;
		logic [LOW_QUEUES-1:0] nearly_full_flag;
		logic [LOW_QUEUES-1:0] full;
	} sqm_flags_s;

	// Entry word leaving through the two-entry buffer
	typedef struct packed {
		logic [31:0] data;
		logic        last;
	} sqm_word_s;
endpackage : sqm_pkg

// ==== hw/sqm_queue_manager.sv ====
// What this block does
// RQ1 - Sixty-four queues, each with own size, entry size and status.
// RQ2 - All queues are circular buffers in one shared 8-Kbyte SRAM.
// RQ3 - Flags of queues 0 to 31 are driven constantly on the flag bus.
// RQ4 - Two interrupt outputs: one for queues 0-31, one for 32-63.
// RQ5 - Bus gives configuration, entry access, status, interrupt setup, raw SRAM.
// RQ6 - Queues 0-31 pick edge of empty, nearly empty, nearly full or full.
// RQ7 - Queues 32-63 always notify on a nearly empty edge.
// RQ8 - Queues 0-31 report six flags including underflow and overflow.
// RQ9 - Queues 32-63 report only nearly empty and full.
// RQ10 - Each queue holds size, entry size, watermarks and source settings.
// RQ11 - Software sets base, size and entry size before first use.
// RQ12 - Watermarks and interrupt enables may change while queues run.
// RQ13 - Occupied entry count of every queue is readable.
// RQ14 - Queue sizes of 16, 32, 64 or 128 words.
// RQ15 - Entry sizes of one, two or four words; one access moves one entry.
// RQ16 - Nearly empty when occupied entries at or below its watermark.
// RQ17 - Nearly full when free entries at or below its watermark.
// RQ18 - Read of empty sets underflow, write of full sets overflow, no change.
// RQ19 - Selected edges latch pending bits; enabled pending drives interrupt.
module sqm_queue_manager (
	// Clock and reset
	input  wire logic                 core_clk_in,
	input  wire logic                 sys_rst_in,
	// APB slave
	input  wire logic                 psel_in,
	input  wire logic                 penable_in,
	input  wire logic                 pwrite_in,
	input  wire logic [15:0]          paddr_in,
	input  wire logic [31:0]          pwdata_in,
	output logic      [31:0]          prdata_out,
	output logic                      pready_out,
	output logic                      pslverr_out,
	// Entry words of the last queue read, one per word
	output sqm_pkg::sqm_word_s        rd_word_out,
	output logic                      rd_valid_out,
	input  wire logic                 rd_ready_in,
	// Flag bus and interrupts
	output sqm_pkg::sqm_flags_s       flag_bus_out,
	output logic                      irq_low_out,
	output logic                      irq_high_out
);
	import sqm_pkg::*;

	typedef enum {ST_IDLE, ST_MOVE, ST_DONE} sqm_state_e;

	// RQ1 per-queue settings and counts
	logic [31:0]           sram [SRAM_WORDS];
	logic [23:0]           cfg  [NUM_QUEUES];
	logic [6:0]            rdp  [NUM_QUEUES];
	logic [CNT_W-1:0]      cnt  [NUM_QUEUES];
	logic [NUM_QUEUES-1:0] uflow, oflow, pend, enab, prev_src;
	logic [NUM_QUEUES-1:0] next_uflow, next_oflow, next_pend, next_enab, src_now;
	logic [NUM_QUEUES-1:0] f_e, f_ne, f_nf, f_f;
	logic [NUM_QUEUES-1:0] src_edge;
	sqm_state_e            state, next_state;
	logic [1:0]            wcnt, next_wcnt;
	logic [31:0]           rdata, next_rdata;
	logic                  ready, next_ready, err, next_err;
	sqm_word_s             buf_q [BUF_DEPTH];
	logic [1:0]            buf_n, next_buf_n;

	// Entry count from size and entry-size codes
	function automatic logic [CNT_W-1:0] entries(input logic [23:0] c);
		logic [7:0] words;
		words = 8'h10 << c[CFG_SIZE_LSB +: 2];
		return words >> c[CFG_ESZ_LSB +: 2];
	endfunction : entries

	// Watermark code to entries: 0,1,2,4..64
	function automatic logic [CNT_W-1:0] wmark(input logic [2:0] k);
		return (k == 3'h0) ? 8'h00 : 8'(8'h01 << (k - 3'h1));
	endfunction : wmark

	// Words per entry
	function automatic logic [2:0] esz(input logic [23:0] c);
		return 3'(3'h1 << c[CFG_ESZ_LSB +: 2]);
	endfunction : esz

	// Per-queue flag and source decode
	genvar g;
	generate
		for (g = 0; g < NUM_QUEUES; g++) begin : g_flag
			// RQ16 nearly empty watermark
			assign f_ne[g] = cnt[g] <= wmark(cfg[g][CFG_NE_LSB +: 3]);
			// RQ17 nearly full watermark
			assign f_nf[g] = (entries(cfg[g]) - cnt[g]) <= wmark(cfg[g][CFG_NF_LSB +: 3]);
			assign f_e[g]  = cnt[g] == 8'h00;
			assign f_f[g]  = cnt[g] == entries(cfg[g]);
			if (g < LOW_QUEUES) begin : g_low
				// RQ6 selectable source
				always_comb begin
					unique case (sqm_src_e'(cfg[g][CFG_SRC_LSB +: 2]))
						SRC_EMPTY:        src_now[g] = f_e[g];
						SRC_NEARLY_EMPTY: src_now[g] = f_ne[g];
						SRC_NEARLY_FULL:  src_now[g] = f_nf[g];
						SRC_FULL:         src_now[g] = f_f[g];
					endcase
				end
			end else begin : g_high
				// RQ7 fixed nearly empty source
				assign src_now[g] = f_ne[g];
			end
		end
	endgenerate

	// Bus decode
	// RQ5 register map decode
	logic        setup, is_q, is_cfg, is_st, is_irq, is_sram, to_full, to_empty;
	logic [5:0]  qid;
	logic [23:0] qc;
	logic [10:0] waddr;
	assign setup   = psel_in && !penable_in;
	assign qid     = paddr_in[7:2];
	assign qc      = cfg[qid];
	assign is_q    = paddr_in[15:12] == OFS_QDATA[15:12] && paddr_in[11:8] == 4'h0;
	assign is_cfg  = paddr_in[15:12] == OFS_QCFG[15:12] && paddr_in[11:8] == 4'h0;
	assign is_st   = paddr_in[15:12] == OFS_QSTAT[15:12] && paddr_in[11:8] == 4'h0;
	assign is_irq  = paddr_in[15:4] == OFS_PEND[15:4];
	assign is_sram = paddr_in[15:13] == OFS_SRAM[15:13];
	assign to_full = f_f[qid];
	assign to_empty = f_e[qid];
	// RQ2 circular address inside the shared SRAM
	assign waddr   = 11'(qc[CFG_BASE_LSB +: 11]
		+ ((11'(rdp[qid]) + (pwrite_in ? 11'(cnt[qid]) * 11'(esz(qc)) : 11'h000)
		+ 11'(wcnt)) & ((11'h010 << qc[CFG_SIZE_LSB +: 2]) - 11'h001)));

	// Transfer sequencing and register answer
	always_comb begin
		next_state = state;
		next_wcnt  = wcnt;
		next_rdata = rdata;
		next_ready = 1'b0;
		next_err   = 1'b0;
		unique case (state)
			ST_IDLE: if (setup) begin
				next_rdata = 32'h00000000;
				if (is_q && !(pwrite_in ? to_full : to_empty)) begin
					next_state = ST_MOVE;
					next_wcnt  = 2'h0;
				end else begin
					next_state = ST_DONE;
					next_ready = 1'b1;
					next_err   = !(is_q || is_cfg || is_st || is_irq || is_sram);
					if (is_cfg)
						next_rdata = {8'h00, qc};
					// RQ13 occupied count with flags
					// RQ8 six flags, lower queues
					if (is_st && qid < 6'(LOW_QUEUES))
						next_rdata = {16'h0000, cnt[qid], 2'b00, oflow[qid], uflow[qid],
							f_f[qid], f_nf[qid], f_ne[qid], f_e[qid]};
					// RQ9 only two flags for upper queues
					if (is_st && qid >= 6'(LOW_QUEUES))
						next_rdata = {16'h0000, cnt[qid], 4'h0, f_f[qid], 1'b0, f_ne[qid], 1'b0};
					if (is_irq)
						next_rdata = paddr_in[3] ? (paddr_in[2] ? enab[63:32] : enab[31:0])
							: (paddr_in[2] ? pend[63:32] : pend[31:0]);
					if (is_sram)
						next_rdata = sram[paddr_in[12:2]];
				end
			end
			// RQ15 one access moves a whole entry
			ST_MOVE: begin
				if (!pwrite_in && buf_n == 2'h2) begin
					next_wcnt = wcnt;
				end else begin
					next_wcnt = wcnt + 2'h1;
					if (!pwrite_in)
						next_rdata = sram[waddr];
					if (3'(wcnt) + 3'h1 == esz(qc)) begin
						next_state = ST_DONE;
						next_ready = 1'b1;
					end
				end
			end
			ST_DONE: next_state = ST_IDLE;
		endcase
	end

	// Either edge of the selected flag
	assign src_edge = src_now ^ prev_src;

	// Interrupt, error flag and enable next values
	always_comb begin
		next_uflow = uflow;
		next_oflow = oflow;
		next_enab  = enab;
		// RQ19 edge of selected flag sets pending
		next_pend  = pend | src_edge;
		if (state == ST_IDLE && setup && pwrite_in && is_irq) begin
			// RQ12 enables change at run time; clear loses to a new edge
			if (paddr_in[3])
				next_enab[paddr_in[2]*32 +: 32] = pwdata_in;
			else
				next_pend[paddr_in[2]*32 +: 32] = (pend[paddr_in[2]*32 +: 32] & ~pwdata_in)
					| src_edge[paddr_in[2]*32 +: 32];
		end
		// RQ18 flag the offending access, queue untouched
		if (state == ST_IDLE && setup && is_q && qid < 6'(LOW_QUEUES)) begin
			if (!pwrite_in && to_empty)
				next_uflow[qid] = 1'b1;
			if (pwrite_in && to_full)
				next_oflow[qid] = 1'b1;
		end
		// Status read clears sticky error flags
		if (state == ST_IDLE && setup && !pwrite_in && is_st) begin
			next_uflow[qid] = 1'b0;
			next_oflow[qid] = 1'b0;
		end
	end

	// Output buffer occupancy
	logic push, pop;
	assign push = state == ST_MOVE && !pwrite_in && buf_n != 2'h2;
	assign pop  = buf_n != 2'h0 && rd_ready_in;
	always_comb begin
		next_buf_n = buf_n + 2'(push) - 2'(pop);
	end

	// Registers, queue state and SRAM
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state    <= ST_IDLE;
			wcnt     <= 2'h0;
			rdata    <= 32'h00000000;
			ready    <= 1'b0;
			err      <= 1'b0;
			uflow    <= '0;
			oflow    <= '0;
			pend     <= '0;
			enab     <= '0;
			// Idle level of every source after reset is high; avoids false edges
			prev_src <= '1;
			buf_n    <= 2'h0;
			for (int i = 0; i < NUM_QUEUES; i++) begin
				// RQ10 settings per queue, cleared at reset
				cfg[i] <= CFG_RST;
				rdp[i] <= 7'h00;
				cnt[i] <= 8'h00;
			end
		end else begin
			state    <= next_state;
			wcnt     <= next_wcnt;
			rdata    <= next_rdata;
			ready    <= next_ready;
			err      <= next_err;
			uflow    <= next_uflow;
			oflow    <= next_oflow;
			pend     <= next_pend;
			enab     <= next_enab;
			prev_src <= src_now;
			buf_n    <= next_buf_n;
			// RQ11 base, sizes written by software; count restarts when base, size or entry size changes
			if (state == ST_IDLE && setup && pwrite_in && is_cfg) begin
				cfg[qid] <= pwdata_in[23:0];
				if (pwdata_in[14:0] != qc[14:0]) begin
					rdp[qid] <= 7'h00;
					cnt[qid] <= 8'h00;
				end
			end
			// RQ14 pointer wraps at queue size
			if (next_state == ST_DONE && state == ST_MOVE) begin
				if (pwrite_in)
					cnt[qid] <= cnt[qid] + 8'h01;
				else begin
					cnt[qid] <= cnt[qid] - 8'h01;
					rdp[qid] <= 7'((8'(rdp[qid]) + 8'(esz(qc)))
						& ((8'h10 << qc[CFG_SIZE_LSB +: 2]) - 8'h01));
				end
			end
		end
	end

	// SRAM writes have no reset
	always_ff @(posedge core_clk_in) begin
		if (state == ST_MOVE && pwrite_in)
			sram[waddr] <= pwdata_in;
		if (state == ST_IDLE && setup && pwrite_in && is_sram)
			sram[paddr_in[12:2]] <= pwdata_in;
	end

	// Two-entry buffer towards the reader; full stalls the entry move
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			if (pop || buf_n == 2'h0)
				buf_q[(buf_n == 2'h2 || (pop && buf_n == 2'h1)) ? 0 : buf_n[0]]
					<= '{data: sram[waddr], last: 3'(wcnt) + 3'h1 == esz(qc)};
			else
				buf_q[1] <= '{data: sram[waddr], last: 3'(wcnt) + 3'h1 == esz(qc)};
		end
		if (pop && buf_n == 2'h2)
			buf_q[0] <= buf_q[1];
	end

	// Outputs straight from flip-flops
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			prdata_out   <= 32'h00000000;
			pready_out   <= 1'b0;
			pslverr_out  <= 1'b0;
			rd_word_out  <= '0;
			rd_valid_out <= 1'b0;
			flag_bus_out <= '0;
			irq_low_out  <= 1'b0;
			irq_high_out <= 1'b0;
		end else begin
			prdata_out   <= next_rdata;
			pready_out   <= next_ready;
			pslverr_out  <= next_err;
			rd_valid_out <= next_buf_n != 2'h0;
			rd_word_out  <= (pop && buf_n == 2'h2) ? buf_q[1] :
				(buf_n == 2'h0 || (pop && buf_n == 2'h1)) ?
				sqm_word_s'{data: sram[waddr], last: 3'(wcnt) + 3'h1 == esz(qc)} : buf_q[0];
			// RQ3 lower-half flags onto the flag bus
			flag_bus_out <= '{empty: f_e[31:0], nearly_empty_flag: f_ne[31:0],
				nearly_full_flag: f_nf[31:0], full: f_f[31:0]};
			// RQ4 one interrupt per half
			irq_low_out  <= |(next_pend[31:0] & next_enab[31:0]);
			irq_high_out <= |(next_pend[63:32] & next_enab[63:32]);
		end
	end
endmodule : sqm_queue_manager

// ==== verification/sqm_queue_manager_monitor.sv ====
module sqm_queue_manager_monitor (
	// Clock and reset
	input wire logic                core_clk_in,
	input wire logic                sys_rst_in,
	// Bus
	input wire logic                psel_in,
	input wire logic                penable_in,
	input wire logic                pwrite_in,
	input wire logic [31:0]         prdata_out,
	input wire logic                pready_out,
	input wire logic                pslverr_out,
	// Stream, flags and interrupts
	input wire sqm_pkg::sqm_word_s  rd_word_out,
	input wire logic                rd_valid_out,
	input wire logic                rd_ready_in,
	input wire sqm_pkg::sqm_flags_s flag_bus_out,
	input wire logic                irq_low_out,
	input wire logic                irq_high_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import sqm_pkg::*;
	logic [2:0] wr_hist;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	// Recent writes; irq register updates in the same cycle as pending
	always_ff @(posedge core_clk_in) begin
		wr_hist <= {wr_hist[1:0], psel_in & pwrite_in};
	end

	sequence apb_setup;
		psel_in && !penable_in;
	endsequence
	sequence apb_answer;
		##[1:40] pready_out;
	endsequence

	answer_bound_a: assert property (apb_setup |-> apb_answer)
		else $error("transfer not answered");
	ready_pulse_a: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property (pready_out |-> psel_in && penable_in)
		else $error("ready without access phase");
	error_quiet_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("error without ready or with data");
	empty_full_a: assert property ((flag_bus_out.empty & flag_bus_out.full) == '0)
		else $error("empty and full together");
	empty_near_a: assert property ((flag_bus_out.empty & ~flag_bus_out.nearly_empty_flag) == '0)
		else $error("empty without nearly empty");
	full_near_a: assert property ((flag_bus_out.full & ~flag_bus_out.nearly_full_flag) == '0)
		else $error("full without nearly full");
	stall_hold_a: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_word_out))
		else $error("stream word lost in stall");
	irq_fall_a: assert property ($fell(irq_low_out) || $fell(irq_high_out) |-> wr_hist != 3'h0)
		else $error("interrupt dropped without a write");
endmodule : sqm_queue_manager_monitor

// ==== verification/sqm_stream_sink.sv ====
module sqm_stream_sink (
	// Clock and reset
	input  wire logic               core_clk_in,
	input  wire logic               sys_rst_in,
	// Stream from the queue manager
	input  wire sqm_pkg::sqm_word_s word_in,
	input  wire logic               valid_in,
	output logic                    ready_out,
	// Bench control
	input  wire logic               stall_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import sqm_pkg::*;
	logic [1:0] phase;
	sqm_word_s  rx_q[$];

	// Slow sink accepts one cycle in four while stalling
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			phase <= 2'h0;
			ready_out <= 1'h0;
		end else begin
			phase <= phase + 2'h1;
			ready_out <= !stall_in || phase == 2'h3;
			if (valid_in && ready_out) begin
				rx_q.push_back(word_in);
			end
		end
	end
endmodule : sqm_stream_sink

// ==== verification/sqm_queue_manager_tb.sv ====
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end

module sqm_queue_manager_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sqm_pkg::*;
	logic        core_clk_in = 1'h0;
	logic        sys_rst_in = 1'h1;
	logic        psel_in = 1'h0;
	logic        penable_in = 1'h0;
	logic        pwrite_in = 1'h0;
	logic [15:0] paddr_in = 16'h0000;
	logic [31:0] pwdata_in = 32'h00000000;
	logic        stall = 1'h0;
	logic [31:0] prdata_out, rd;
	logic        pready_out, pslverr_out, rd_valid_out, rd_ready_in, irq_low_out, irq_high_out;
	logic        err;
	sqm_word_s   rd_word_out;
	sqm_flags_s  flag_bus_out;
	int          n_errors = 0;
	int          check_count = 0;
	int          ne_wm, nf_wm;

	sqm_queue_manager sqm_queue_manager_i (.core_clk_in, .sys_rst_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.rd_word_out, .rd_valid_out, .rd_ready_in, .flag_bus_out, .irq_low_out, .irq_high_out);
	sqm_stream_sink sqm_stream_sink_i (.core_clk_in, .sys_rst_in, .word_in(rd_word_out),
		.valid_in(rd_valid_out), .ready_out(rd_ready_in), .stall_in(stall));

	always #5 core_clk_in = ~core_clk_in;

	// One transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'h1;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (pready_out !== 1'h1 && n < 200);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		if (n >= 200) begin
			n_errors++;
			$display("unexpected at %0t: no ready", $time);
		end
	endtask : apb

	task automatic rdx(input logic [15:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdx

	function automatic logic [31:0] cfg(input int b, ne, nf, src, esz);
		return 32'(b | ne << CFG_NE_LSB | nf << CFG_NF_LSB | src << CFG_SRC_LSB | esz << CFG_ESZ_LSB);
	endfunction : cfg

	// Expected status of a 16-entry queue from its count
	function automatic logic [31:0] st(input int c, input logic [1:0] ou);
		return {16'h0, 8'(c), 2'h0, ou, (c == 16), (16 - c <= nf_wm), (c <= ne_wm), (c == 0)};
	endfunction : st

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (8) @(posedge core_clk_in);
		sys_rst_in <= 1'h0;
		rdx(OFS_QCFG, {8'h0, CFG_RST});
		ne_wm = 4;
		nf_wm = 2;
		apb(1'h1, OFS_QCFG, cfg(0, 3, 2, SRC_NEARLY_EMPTY, 0));
		apb(1'h1, OFS_ENAB, 32'h1);
		rdx(OFS_QDATA, 32'h0);
		rdx(OFS_QSTAT, st(0, 2'h1));
		rdx(OFS_QSTAT, st(0, 2'h0));
		for (int i = 1; i <= 16; i++) begin
			apb(1'h1, OFS_QDATA, 32'(32'hA0 + i));
			if (i == 8) begin
				apb(1'h1, OFS_QCFG, cfg(0, 4, 2, SRC_NEARLY_EMPTY, 0));
				ne_wm = 8;
			end
			rdx(OFS_QSTAT, st(i, 2'h0));
		end
		`CHK(flag_bus_out.full[0], 1'h1)
		apb(1'h1, OFS_QDATA, 32'h0000DEAD);
		rdx(OFS_QSTAT, st(16, 2'h2));
		rdx(OFS_SRAM, 32'hA1);
		apb(1'h1, OFS_SRAM + 16'h1FFC, 32'h5A5A1234);
		rdx(OFS_SRAM + 16'h1FFC, 32'h5A5A1234);
		rdx(OFS_PEND, 32'h1);
		`CHK(irq_low_out, 1'h1)
		apb(1'h1, OFS_PEND, 32'h1);
		rdx(OFS_PEND, 32'h0);
		`CHK(irq_low_out, 1'h0)
		sqm_stream_sink_i.rx_q.delete();
		stall <= 1'h1;
		for (int i = 1; i <= 16; i++) begin
			rdx(OFS_QDATA, 32'(32'hA0 + i));
			rdx(OFS_QSTAT, st(16 - i, 2'h0));
		end
		stall <= 1'h0;
		// Let the sink drain the last buffered words
		repeat (6) @(posedge core_clk_in);
		`CHK(sqm_stream_sink_i.rx_q.size(), 16)
		foreach (sqm_stream_sink_i.rx_q[i]) `CHK(sqm_stream_sink_i.rx_q[i], {32'(32'hA1 + i), 1'h1})
		// Every notification source on queue 1
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, OFS_QCFG + 16'h4, cfg(16 + 16 * s, 0, 0, s, 0));
			apb(1'h1, OFS_PEND, 32'hFFFFFFFF);
			apb(1'h1, OFS_QDATA + 16'h4, 32'(s));
			rdx(OFS_PEND, {30'h0, (s < 2), 1'h0});
		end
		apb(1'h1, OFS_QCFG + 16'h80, cfg(48, 0, 0, SRC_FULL, 0));
		apb(1'h1, OFS_ENAB + 16'h4, 32'h1);
		rdx(OFS_QDATA + 16'h80, 32'h0);
		rdx(OFS_QSTAT + 16'h80, 32'h2);
		apb(1'h1, OFS_QDATA + 16'h80, 32'h7);
		rdx(OFS_QSTAT + 16'h80, 32'h100);
		rdx(OFS_PEND + 16'h4, 32'h1);
		`CHK(irq_high_out, 1'h1)
		apb(1'h1, OFS_PEND + 16'h4, 32'h1);
		rdx(OFS_PEND + 16'h4, 32'h0);
		`CHK(irq_high_out, 1'h0)
		apb(1'h1, OFS_QCFG + 16'h8, cfg(64, 0, 0, 0, 1));
		apb(1'h1, OFS_QDATA + 16'h8, 32'h5555AAAA);
		rdx(OFS_QSTAT + 16'h8, 32'h100);
		sqm_stream_sink_i.rx_q.delete();
		rdx(OFS_QDATA + 16'h8, 32'h5555AAAA);
		rdx(OFS_QSTAT + 16'h8, 32'h3);
		`CHK(sqm_stream_sink_i.rx_q[0].last, 1'h0)
		`CHK(sqm_stream_sink_i.rx_q[1], {32'h5555AAAA, 1'h1})
		rdx(16'h6000, 32'h0);
		`CHK(err, 1'h1)
		close_out();
	end

	// Watchdog well past the expected run length
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule : sqm_queue_manager_tb

bind sqm_queue_manager sqm_queue_manager_monitor sqm_queue_manager_monitor_i (.core_clk_in,
	.sys_rst_in, .psel_in, .penable_in, .pwrite_in, .prdata_out, .pready_out, .pslverr_out,
	.rd_word_out, .rd_valid_out, .rd_ready_in, .flag_bus_out, .irq_low_out, .irq_high_out);
